// ==== design/csimc_top.sv ====
/*
 Sleep and initialization mode control of a CAN controller, APB registers.
 Assumes the protocol engine on ref_clk supplies rx_busy, tx_bufs_empty,
 proto_tx and error counters; can_rx is an asynchronous pin.
*/
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module csimc_top #(
    parameter int BIT_CYCLES = csimc_pkg::BIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic can_rx,
    input wire logic proto_tx,
    input wire logic rx_busy,
    input wire logic tx_bufs_empty,
    input wire logic bus_off,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic [7:0] rx_err_count,
    input wire logic [7:0] tx_err_count,
    output logic bus_transmit_pin,
    output logic sleep_acknowledge,
    output logic init_acknowledge,
    output logic wake_irq,
    output logic engine_abort,
    output logic engine_synced
);
    import csimc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [REG_W-1:0] store_r [NREG];
    csimc_mode_t mode_r;
    csimc_mode_t mode_nxt;
    logic init_request_r;
    logic init_request_nxt;
    logic sleep_request_r;
    logic sleep_request_nxt;
    logic wake_interrupt_flag_r;
    logic wake_lat_r;
    logic sleep_ack_r;
    logic init_ack_r;
    logic tx_pin_r;
    logic wake_irq_r;
    logic abort_r;
    logic synced_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_prev_r;
    logic [15:0] div_r;
    logic bit_en_r;
    logic resync_done;
    logic [REG_W-1:0] rd_byte;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [IDX_W-1:0] idx = paddr[IDX_W+1:2];
    wire addr_in_range = (paddr[31:IDX_W+2] == '0);
    wire unmapped = !addr_in_range || MASK_UNMAPPED[idx];
    wire apb_done = psel && penable && pready_r;
    wire apb_wr = apb_done && pwrite && !unmapped;
    wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];
    wire in_init = init_request_r && init_ack_r;
    wire in_sleep = sleep_request_r && sleep_ack_r;
    wire wr_ctl0 = apb_wr && (idx == IX_CTL0);
    wire wr_rflg = apb_wr && (idx == IX_RFLG);
    wire init_entry = (mode_r != MD_INIT) && (mode_nxt == MD_INIT);
    wire bus_idle = !rx_busy && tx_bufs_empty;
    wire rx_fall = rx_prev_r && !rx_sync_r;
    wire wake_evt = (mode_r == MD_SLEEP) && wake_lat_r && rx_fall;
    wire wake_irq_en = store_r[IX_RIER][B_WAKE_IRQ_EN];
    wire stop_in_wait = store_r[IX_CTL0][B_STOP_IN_WAIT];
    wire force_recessive = init_request_nxt || stop_mode || (wait_mode && stop_in_wait);
    // Init entry keeps the wake enable of mode control at its current value
    wire [REG_W-1:0] keep_ctl0 = REG_W'(1 << B_WAKE_EN);
    wire [REG_W-1:0] ctl0_init_val = (RST_CTL0 & ~keep_ctl0) | (store_r[IX_CTL0] & keep_ctl0);

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bus_transmit_pin = tx_pin_r;
    assign sleep_acknowledge = sleep_ack_r;
    assign init_acknowledge = init_ack_r;
    assign wake_irq = wake_irq_r;
    assign engine_abort = abort_r;
    assign engine_synced = synced_r;

    // ------------------------------------------------------------
    // Request bits
    // ------------------------------------------------------------
    always_comb
    begin
        init_request_nxt = init_request_r;
        if (wr_ctl0 && wbyte[B_INIT_REQ])
            init_request_nxt = 1'b1;
        else if (wr_ctl0 && in_init)
            init_request_nxt = 1'b0;
    end

    always_comb
    begin
        sleep_request_nxt = sleep_request_r;
        if (wake_evt)
            sleep_request_nxt = 1'b0;
        else if (wr_ctl0 && wbyte[B_SLEEP_REQ] && !wake_interrupt_flag_r)
            sleep_request_nxt = 1'b1;
        else if (wr_ctl0 && !wbyte[B_SLEEP_REQ] && in_sleep)
            sleep_request_nxt = 1'b0;
    end

    // ------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode_r;
        if (init_request_r && mode_r != MD_INIT)
            mode_nxt = MD_INIT;
        else
        begin
            unique case (mode_r)
                MD_RUN:
                    if (sleep_request_r && bus_idle)
                        mode_nxt = MD_SLEEP;
                MD_SLEEP:
                    if (!sleep_request_r)
                        mode_nxt = MD_RUN;
                MD_INIT:
                    if (!init_request_r)
                        mode_nxt = MD_RESYNC;
                MD_RESYNC:
                    if (resync_done)
                        mode_nxt = MD_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mode_r <= MD_INIT;
        else
            mode_r <= mode_nxt;
    end

    // Acknowledges only while the request still stands
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            init_ack_r <= RST_CTL0[B_INIT_REQ];
            sleep_ack_r <= 1'b0;
        end
        else
        begin
            init_ack_r <= (mode_nxt == MD_INIT) && init_request_r;
            sleep_ack_r <= (mode_nxt == MD_SLEEP) && sleep_request_r;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            abort_r <= 1'b0;
            synced_r <= 1'b0;
        end
        else
        begin
            abort_r <= init_entry;
            synced_r <= (mode_nxt == MD_RUN) || (mode_nxt == MD_SLEEP);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            init_request_r <= RST_CTL0[B_INIT_REQ];
            sleep_request_r <= RST_CTL0[B_SLEEP_REQ];
        end
        else
        begin
            init_request_r <= init_request_nxt;
            sleep_request_r <= sleep_request_nxt;
        end
    end

    // ------------------------------------------------------------
    // Wake handling
    // ------------------------------------------------------------
    // Wake enable frozen for the whole sleep period
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wake_lat_r <= 1'b0;
        else if (mode_r != MD_SLEEP)
            wake_lat_r <= store_r[IX_CTL0][B_WAKE_EN];
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wake_interrupt_flag_r <= 1'b0;
        else if (wake_evt)
            wake_interrupt_flag_r <= 1'b1;
        else if (wr_rflg && wbyte[B_WAKE_FLAG])
            wake_interrupt_flag_r <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            wake_irq_r <= 1'b0;
        else
            wake_irq_r <= wake_interrupt_flag_r && wake_irq_en;
    end

    // ------------------------------------------------------------
    // Register store
    // ------------------------------------------------------------
    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
        wire open_now = !MASK_LOCKED[g] || in_init;
        wire wr_here = apb_wr && (idx == IDX_W'(g)) && !MASK_RO[g] && open_now;
        wire clr_here = init_entry && MASK_INIT_RST[g];
        always_ff @(posedge ref_clk)
        begin
            if (srst)
                store_r[g] <= reset_value(g);
            else if (clr_here && g == int'(IX_CTL0))
                store_r[g] <= ctl0_init_val;
            else if (clr_here)
                store_r[g] <= reset_value(g);
            else if (wr_here)
                store_r[g] <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        rd_byte = store_r[idx];
        if (idx == IX_CTL0)
        begin
            rd_byte[B_INIT_REQ] = init_request_r;
            rd_byte[B_SLEEP_REQ] = sleep_request_r;
            rd_byte[B_WAKE_EN] = store_r[IX_CTL0][B_WAKE_EN];
        end
        else if (idx == IX_CTL1)
        begin
            rd_byte[B_INIT_ACK] = init_ack_r;
            rd_byte[B_SLEEP_ACK] = sleep_ack_r;
        end
        else if (idx == IX_RFLG)
            rd_byte[B_WAKE_FLAG] = wake_interrupt_flag_r;
        else if (idx == IX_RXERR)
            rd_byte = rx_err_count;
        else if (idx == IX_TXERR)
            rd_byte = tx_err_count;
        if (unmapped)
            rd_byte = '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && unmapped;
            if (psel && !penable && !pwrite)
                prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Bus pin handling
    // ------------------------------------------------------------
    // Two-stage synchroniser plus edge history, idle recessive
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end
        else
        begin
            rx_meta_r <= can_rx;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            tx_pin_r <= 1'b1;
        else if (force_recessive)
            tx_pin_r <= 1'b1;
        else
            tx_pin_r <= (mode_r == MD_RUN) ? proto_tx : 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst || div_r == 16'(BIT_CYCLES - 1))
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
        bit_en_r <= !srst && (div_r == 16'(BIT_CYCLES - 1));
    end

    csimc_resync u_resync (
        .ref_clk(ref_clk),
        .srst(srst),
        .active(mode_r == MD_RESYNC),
        .bit_en(bit_en_r),
        .rx_bit(rx_sync_r),
        .bus_off(bus_off),
        .done(resync_done)
    );
endmodule : csimc_top

// ==== design/csimc_pkg.sv ====
/*
 Constants for the CAN sleep and initialization mode control block.
 Assumes an APB slave with 32-bit data; registers are 8 bits in the low byte.
*/
package csimc_pkg;
    localparam int REG_W = 8;
    localparam int IDX_W = 5;
    localparam int NREG = 32;
    // ------------------------------------------------------------
    // Register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IX_CTL0 = 5'h00;
    localparam logic [IDX_W-1:0] IX_CTL1 = 5'h01;
    localparam logic [IDX_W-1:0] IX_RFLG = 5'h02;
    localparam logic [IDX_W-1:0] IX_RIER = 5'h03;
    localparam logic [IDX_W-1:0] IX_TFLG = 5'h04;
    localparam logic [IDX_W-1:0] IX_RXERR = 5'h0C;
    localparam logic [IDX_W-1:0] IX_TXERR = 5'h0D;
    // Registers returned to reset value on init entry; CTL0 keeps its wake enable bit
    localparam logic [NREG-1:0] MASK_INIT_RST = 32'h0000_01FD;
    // Registers writable only inside init mode
    localparam logic [NREG-1:0] MASK_LOCKED = 32'hFFFF_0E02;
    // Read-only and unmapped registers
    localparam logic [NREG-1:0] MASK_RO = 32'h0000_3000;
    localparam logic [NREG-1:0] MASK_UNMAPPED = 32'h0000_C000;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_INIT_REQ = 0;
    localparam int B_SLEEP_REQ = 1;
    localparam int B_WAKE_EN = 2;
    localparam int B_STOP_IN_WAIT = 5;
    localparam int B_INIT_ACK = 0;
    localparam int B_SLEEP_ACK = 1;
    localparam int B_WAKE_FLAG = 7;
    localparam int B_WAKE_IRQ_EN = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_CTL0 = 8'h01;
    localparam logic [REG_W-1:0] RST_TFLG = 8'h07;
    localparam logic [REG_W-1:0] RST_OTHER = 8'h00;
    // ------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int BIT_RATE_KBPS = 500;
    localparam int BIT_CYCLES = (CLK_MHZ * 1000) / BIT_RATE_KBPS;
    localparam int RECESSIVE_RUN = 11;
    localparam int BUSOFF_RUNS = 128;

    typedef enum logic [1:0] {MD_RUN, MD_SLEEP, MD_INIT, MD_RESYNC} csimc_mode_t;

    function automatic logic [REG_W-1:0] reset_value(input int idx);
        reset_value = (idx == 0) ? RST_CTL0 : (idx == 4) ? RST_TFLG : RST_OTHER;
    endfunction : reset_value
endpackage : csimc_pkg

// ==== design/csimc_resync.sv ====
/*
 Counts runs of consecutive recessive bits after init is left.
 Assumes rx_bit is already synchronised and bit_en marks one sample per bit.
*/
`timescale 1ns/1ns
module csimc_resync #(
    parameter int RUN_BITS = csimc_pkg::RECESSIVE_RUN,
    parameter int BUSOFF_RUNS = csimc_pkg::BUSOFF_RUNS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic active,
    input wire logic bit_en,
    input wire logic rx_bit,
    input wire logic bus_off,
    output logic done
);
    import csimc_pkg::*;

    logic [3:0] run_r;
    logic [7:0] runs_r;
    logic done_r;
    wire run_full = (run_r == 4'(RUN_BITS - 1));
    wire [7:0] need = bus_off ? 8'(BUSOFF_RUNS) : 8'h01;

    assign done = done_r;

    // ------------------------------------------------------------
    // Run and occurrence counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || !active)
        begin
            run_r <= 4'h0;
            runs_r <= 8'h00;
            done_r <= 1'b0;
        end
        else if (bit_en && !done_r)
        begin
            if (!rx_bit)
                run_r <= 4'h0;
            else if (run_full)
            begin
                run_r <= 4'h0;
                runs_r <= runs_r + 8'h01;
                done_r <= (runs_r + 8'h01) >= need;
            end
            else
                run_r <= run_r + 4'h1;
        end
    end
endmodule : csimc_resync

// ==== verif/csimc_bus_model.sv ====
/*
 Other nodes on the CAN bus, wired-AND with our transmit pin.
 Assumes traffic is driven on ref_clk edges by the bench.
*/
`timescale 1ns/1ns
module csimc_bus_model #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic traffic,
    input wire logic node_tx,
    output logic can_rx
);
    int cnt = 0;
    logic other_tx = 1'b1;
    // Idle bus is recessive; traffic toggles bits
    always @(posedge ref_clk)
    begin
        if (!traffic)
        begin
            cnt <= 0;
            other_tx <= 1'b1;
        end
        else if (cnt == BIT_CYCLES - 1)
        begin
            cnt <= 0;
            other_tx <= ~other_tx;
        end
        else
            cnt <= cnt + 1;
    end
    assign can_rx = other_tx & node_tx;
endmodule : csimc_bus_model

// ==== verif/csimc_checker.sv ====
/*
 Port assertions for the mode control block.
 Assumes it is bound to csimc_top.
*/
`timescale 1ns/1ns
module csimc_checker #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic can_rx,
    input wire logic rx_busy,
    input wire logic tx_bufs_empty,
    input wire logic stop_mode,
    input wire logic bus_transmit_pin,
    input wire logic sleep_acknowledge,
    input wire logic init_acknowledge,
    input wire logic engine_abort,
    input wire logic engine_synced
);
    localparam int RUN_MIN = 9 * BIT_CYCLES;
    logic [11:0] run_r;
    wire logic [11:0] run_nxt = !can_rx ? 12'h000 : (&run_r) ? run_r : run_r + 12'h001;
    wire logic ctl0_wr = psel && penable && pready && pwrite && paddr[6:2] == 5'h00;
    always_ff @(posedge ref_clk)
    begin
        run_r <= srst ? 12'h000 : run_nxt;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_init_set;
        ctl0_wr && pwdata[0];
    endsequence
    sequence s_abort;
        engine_abort ##1 (!engine_abort && !engine_synced);
    endsequence
    a_init_recessive: assert property (s_init_set |=> bus_transmit_pin)
        else $error("pin not recessive after init request");
    a_init_ack_rise: assert property (s_init_set and !init_acknowledge |-> ##2 init_acknowledge)
        else $error("init acknowledge late");
    a_init_abort: assert property (s_init_set and !init_acknowledge |-> ##2 s_abort)
        else $error("no abort pulse on init entry");
    a_stop_recessive: assert property (stop_mode |=> bus_transmit_pin)
        else $error("pin not recessive in stop");
    a_sleep_idle: assert property ($rose(sleep_acknowledge) |-> $past(tx_bufs_empty) && !$past(rx_busy))
        else $error("sleep entered while bus busy");
    a_sleep_holds: assert property (sleep_acknowledge && run_r >= 12'd8 && !psel && !$past(psel)
        && !$past(psel, 2) |=> sleep_acknowledge)
        else $error("sleep left without cause");
    a_resync_run: assert property ($rose(engine_synced) |-> run_r >= RUN_MIN)
        else $error("resync before recessive run");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_apb_unmapped: assert property (psel && !penable && paddr[6:3] == 4'h7 |=> pslverr && pready)
        else $error("no error for unmapped index");
endmodule : csimc_checker

bind csimc_top csimc_checker #(.BIT_CYCLES(BIT_CYCLES)) i_csimc_checker (.ref_clk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .can_rx, .rx_busy, .tx_bufs_empty,
    .stop_mode, .bus_transmit_pin, .sleep_acknowledge, .init_acknowledge, .engine_abort,
    .engine_synced);

// ==== verif/csimc_top_test.sv ====
/*
 Register-level test of the mode control block.
 Assumes the bus model and the bound checker.
*/
`timescale 1ns/1ns
module csimc_top_test;
    import csimc_pkg::*;
    localparam int BC = 4;
    logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, d;
    logic pready, pslverr, can_rx, e, proto_tx = 1'b1, rx_busy = 1'b0, tx_bufs_empty = 1'b1;
    logic bus_off = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0, traffic = 1'b0, bus_transmit_pin;
    logic sleep_acknowledge, init_acknowledge, wake_irq;
    int bad_count = 0, samples_checked = 0, n;
    csimc_top #(.BIT_CYCLES(BC)) i_csimc_top (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .can_rx, .proto_tx, .rx_busy, .tx_bufs_empty,
        .bus_off, .stop_mode, .wait_mode, .rx_err_count(8'h3C), .tx_err_count(8'hC3),
        .bus_transmit_pin, .sleep_acknowledge, .init_acknowledge, .wake_irq, .engine_abort(),
        .engine_synced());
    csimc_bus_model #(.BIT_CYCLES(BC)) i_csimc_bus_model (.ref_clk, .traffic,
        .node_tx(bus_transmit_pin), .can_rx);
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    task end_of_test;
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {25'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [4:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(d, {24'h0, exp});
    endtask : rd
    task wait_on(input int sel, input logic val);
        n = 0;
        while (n < 8000 && (sel == 0 ? sleep_acknowledge : sel == 1 ? init_acknowledge
            : i_csimc_top.engine_synced) !== val)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_on
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_of_test;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        rd(IX_CTL0, RST_CTL0);
        rd(IX_CTL1, 8'h01);
        rd(IX_TFLG, RST_TFLG);
        apb(1'b1, 5'h09, 8'h5A);
        rd(5'h09, 8'h5A);
        apb(1'b0, 5'h0E, 8'h00);
        check({31'h0, e}, 32'h1);
        rd(IX_RXERR, 8'h3C);
        apb(1'b1, IX_CTL0, 8'h00);
        wait_on(1, 1'b0);
        wait_on(2, 1'b1);
        check({31'h0, n >= 9 * BC && n <= 12 * BC + 8}, 32'h1);
        rd(IX_RXERR, 8'h3C);
        rd(IX_TXERR, 8'hC3);
        apb(1'b1, 5'h09, 8'hA5);
        rd(5'h09, 8'h5A);
        apb(1'b1, IX_RIER, 8'h80);
        apb(1'b1, IX_CTL0, 8'h04);
        rx_busy <= 1'b1;
        tx_bufs_empty <= 1'b0;
        apb(1'b1, IX_CTL0, 8'h06);
        apb(1'b1, IX_CTL0, 8'h04);
        rd(IX_CTL0, 8'h06);
        rx_busy <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({31'h0, sleep_acknowledge}, 32'h0);
        tx_bufs_empty <= 1'b1;
        wait_on(0, 1'b1);
        rd(IX_CTL1, 8'h02);
        traffic <= 1'b1;
        wait_on(0, 1'b0);
        traffic <= 1'b0;
        check({31'h0, n < 40}, 32'h1);
        rd(IX_CTL0, 8'h04);
        rd(IX_RFLG, 8'h80);
        check({31'h0, wake_irq}, 32'h1);
        apb(1'b1, IX_CTL0, 8'h06);
        rd(IX_CTL0, 8'h04);
        apb(1'b1, IX_RFLG, 8'h80);
        repeat (3) @(posedge ref_clk);
        check({31'h0, wake_irq}, 32'h0);
        apb(1'b1, IX_CTL0, 8'h02);
        wait_on(0, 1'b1);
        traffic <= 1'b1;
        repeat (30) @(posedge ref_clk);
        traffic <= 1'b0;
        check({31'h0, sleep_acknowledge}, 32'h1);
        apb(1'b1, IX_CTL0, 8'h00);
        wait_on(0, 1'b0);
        rd(IX_CTL0, 8'h00);
        proto_tx <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, bus_transmit_pin}, 32'h0);
        stop_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        stop_mode <= 1'b0;
        check({31'h0, bus_transmit_pin}, 32'h1);
        wait_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({31'h0, bus_transmit_pin}, 32'h0);
        apb(1'b1, IX_CTL0, 8'h20);
        repeat (2) @(posedge ref_clk);
        check({31'h0, bus_transmit_pin}, 32'h1);
        wait_mode <= 1'b0;
        apb(1'b1, 5'h05, 8'h33);
        apb(1'b1, IX_CTL0, 8'h05);
        @(posedge ref_clk);
        check({31'h0, bus_transmit_pin}, 32'h1);
        wait_on(1, 1'b1);
        rd(5'h05, 8'h00);
        rd(IX_CTL0, 8'h05);
        proto_tx <= 1'b1;
        bus_off <= 1'b1;
        apb(1'b1, IX_CTL0, 8'h04);
        wait_on(2, 1'b1);
        check({31'h0, n >= 128 * 10 * BC && n < 8000}, 32'h1);
        apb(1'b1, IX_CTL0, 8'h06);
        wait_on(0, 1'b1);
        apb(1'b1, IX_CTL0, 8'h07);
        wait_on(1, 1'b1);
        rd(IX_CTL1, 8'h01);
        rd(IX_CTL0, 8'h07);
        end_of_test;
    end
endmodule : csimc_top_test
